/* File: rfc_map.svh */
`ifndef RFC_MAP_SVH
`define RFC_MAP_SVH
// ------------------------------------------------------------
// Stored configuration layout
// ------------------------------------------------------------
`define RFC_PAY_BASE     16'h0100
`define RFC_GEN_BASE     16'h0200
`define RFC_SCHEME_BYTES 16'h0020
`define RFC_ADDR_RST     16'h0000
`define RFC_DATA_RST     32'h0000_0000
`define RFC_SET_WORDS    8
`define RFC_ELEM_BYTES   4
`endif

/* File: rfc_pkg.sv */
package rfc_pkg;
   // ------------------------------------------------------------
   // Types
   // ------------------------------------------------------------
   typedef enum logic {RFC_LOOP_GEN, RFC_LOOP_PAY} rfc_loop_t;
   typedef enum logic [2:0] {RFC_ST_RESET, RFC_ST_REQ, RFC_ST_WAIT, RFC_ST_READY,
                             RFC_ST_DL} rfc_state_t;
   typedef struct packed {
      logic        wr;
      logic [7:0]  idx;
      logic [31:0] data;
   } rfc_cfg_wr_t;
endpackage : rfc_pkg

/* File: rfc_loader.sv */
// How it works
// - A reset on rst_n with por_n held high that follows the download command brings the block up in download mode.
// - Two configuration sets are kept, one for the payment loop and one for the general loop.
// - Activating a loop starts a load of its own set from the non-volatile store.
// - The modulation scheme chosen by the loop selects which stored part of the set is applied.
// - All configuration comes from the non-volatile store, so it survives power loss.
// - Byte arrays keep their first element at the lowest address.
// - A 16-bit value has its low byte at the lowest address.
// - 16-bit arrays go element by element, each element low byte first.
// - A 32-bit value is stored least significant byte first.
// - The store is read in ascending address order, low byte first.
// - The loop is chosen from the synchronised level of the selection pin.
// - A change of that level resets the stack, clears buffers and resets RF before new polling.
`include "rfc_map.svh"
module rfc_loader #(
   parameter int unsigned SET_WORDS  = `RFC_SET_WORDS,
   parameter int unsigned ELEM_BYTES = `RFC_ELEM_BYTES
) (
   // Clock and resets
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              por_n,
   // Host and loop control
   input  wire logic              mode_pin,
   input  wire logic              dl_cmd,
   input  wire logic [1:0]        mod_sel,
   input  wire logic              poll_start,
   // Non-volatile store read port
   input  wire logic [7:0]        nvm_rdata,
   input  wire logic              nvm_valid,
   output logic                   nvm_req_q,
   output logic [15:0]            nvm_addr_q,
   // Configuration out
   output rfc_pkg::rfc_cfg_wr_t   cfg_q,
   output rfc_pkg::rfc_loop_t     cfg_set_q,
   // Status and resets out
   output logic                   download_mode_q,
   output logic                   stack_rst_q,
   output logic                   buf_clr_q,
   output logic                   rf_rst_q,
   output logic                   poll_ready_q,
   output logic                   rf_tx_en_q
);
   import rfc_pkg::*;

   // ------------------------------------------------------------
   // Byte order
   // ------------------------------------------------------------
   function automatic logic [31:0] rfc_assemble(input int unsigned eb, input logic [31:0] b);
      unique case (eb)
         1:       rfc_assemble = {b[7:0], b[15:8], b[23:16], b[31:24]};
         2:       rfc_assemble = {b[15:8], b[7:0], b[31:24], b[23:16]};
         default: rfc_assemble = b;
      endcase
   endfunction : rfc_assemble

   function automatic logic [15:0] rfc_base(input rfc_loop_t l, input logic [1:0] s);
      rfc_base = ((l == RFC_LOOP_PAY) ? `RFC_PAY_BASE : `RFC_GEN_BASE)
                 + 16'(16'(s) * `RFC_SCHEME_BYTES);
   endfunction : rfc_base

   // ------------------------------------------------------------
   // Pin synchroniser and download flag
   // ------------------------------------------------------------
   logic       mode_s1_q, mode_s2_q;
   logic       dl_pend_q, dl_pend_d;

   always_comb begin
      dl_pend_d = dl_pend_q;
      if (dl_cmd) begin
         dl_pend_d = 1'b1;
      end
   end

   // No reset, so the pin level has settled when reset ends
   always_ff @(posedge clk_sys) begin
      mode_s1_q <= mode_pin;
      mode_s2_q <= mode_s1_q;
   end

   always_ff @(posedge clk_sys) begin
      if (!por_n) begin
         dl_pend_q <= 1'b0;
      end else begin
         dl_pend_q <= dl_pend_d;
      end
   end

   // ------------------------------------------------------------
   // Loader state machine
   // ------------------------------------------------------------
   rfc_state_t  st_q, st_d;
   rfc_loop_t   loop_d;
   logic [1:0]  scheme_q, scheme_d;
   logic [1:0]  bcnt_q, bcnt_d;
   logic [7:0]  wcnt_q, wcnt_d;
   logic [31:0] bytes_q, bytes_d;
   logic [15:0] addr_d;
   logic        req_d, stk_d, tx_d, rdy_d;
   rfc_cfg_wr_t cfg_d;
   logic        loop_chg;

   assign loop_chg = (mode_s2_q ? RFC_LOOP_PAY : RFC_LOOP_GEN) != cfg_set_q;

   always_comb begin
      st_d     = st_q;
      loop_d   = cfg_set_q;
      scheme_d = scheme_q;
      bcnt_d   = bcnt_q;
      wcnt_d   = wcnt_q;
      bytes_d  = bytes_q;
      addr_d   = nvm_addr_q;
      req_d    = 1'b0;
      stk_d    = 1'b0;
      tx_d     = rf_tx_en_q;
      rdy_d    = poll_ready_q;
      cfg_d    = '{wr: 1'b0, idx: cfg_q.idx, data: cfg_q.data};
      unique case (st_q)
         RFC_ST_RESET: begin
            stk_d    = 1'b1;
            tx_d     = 1'b0;
            rdy_d    = 1'b0;
            loop_d   = mode_s2_q ? RFC_LOOP_PAY : RFC_LOOP_GEN;
            scheme_d = mod_sel;
            addr_d   = rfc_base(loop_d, mod_sel);
            bcnt_d   = 2'h0;
            wcnt_d   = 8'h00;
            st_d     = RFC_ST_REQ;
         end
         RFC_ST_REQ: begin
            req_d = 1'b1;
            st_d  = RFC_ST_WAIT;
         end
         RFC_ST_WAIT: begin
            req_d = 1'b1;
            if (nvm_valid) begin
               req_d   = 1'b0;
               bytes_d = {nvm_rdata, bytes_q[31:8]};
               addr_d  = 16'(nvm_addr_q + 16'h0001);
               bcnt_d  = 2'(bcnt_q + 2'h1);
               st_d    = RFC_ST_REQ;
               if (bcnt_q == 2'h3) begin
                  cfg_d  = '{wr: 1'b1, idx: wcnt_q,
                             data: rfc_assemble(ELEM_BYTES, bytes_d)};
                  wcnt_d = 8'(wcnt_q + 8'h01);
                  if (32'(wcnt_q) == SET_WORDS - 1) begin
                     rdy_d = 1'b1;
                     st_d  = RFC_ST_READY;
                  end
               end
            end
         end
         RFC_ST_READY: begin
            if (loop_chg) begin
               st_d = RFC_ST_RESET;
            end else if (mod_sel != scheme_q) begin
               tx_d     = 1'b0;
               rdy_d    = 1'b0;
               scheme_d = mod_sel;
               addr_d   = rfc_base(cfg_set_q, mod_sel);
               bcnt_d   = 2'h0;
               wcnt_d   = 8'h00;
               st_d     = RFC_ST_REQ;
            end else if (poll_start) begin
               tx_d = 1'b1;
            end
         end
         RFC_ST_DL: begin
            st_d = RFC_ST_DL;
         end
         default: st_d = RFC_ST_RESET;
      endcase
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         st_q            <= dl_pend_q ? RFC_ST_DL : RFC_ST_RESET;
         download_mode_q <= dl_pend_q;
         cfg_set_q       <= RFC_LOOP_GEN;
         scheme_q        <= 2'h0;
         bcnt_q          <= 2'h0;
         wcnt_q          <= 8'h00;
         bytes_q         <= `RFC_DATA_RST;
         nvm_addr_q      <= `RFC_ADDR_RST;
         nvm_req_q       <= 1'b0;
         stack_rst_q     <= 1'b0;
         buf_clr_q       <= 1'b0;
         rf_rst_q        <= 1'b0;
         rf_tx_en_q      <= 1'b0;
         poll_ready_q    <= 1'b0;
         cfg_q           <= '{wr: 1'b0, idx: 8'h00, data: `RFC_DATA_RST};
      end else begin
         st_q            <= st_d;
         download_mode_q <= download_mode_q;
         cfg_set_q       <= loop_d;
         scheme_q        <= scheme_d;
         bcnt_q          <= bcnt_d;
         wcnt_q          <= wcnt_d;
         bytes_q         <= bytes_d;
         nvm_addr_q      <= addr_d;
         nvm_req_q       <= req_d;
         stack_rst_q     <= stk_d;
         buf_clr_q       <= stk_d;
         rf_rst_q        <= stk_d;
         rf_tx_en_q      <= tx_d;
         poll_ready_q    <= rdy_d;
         cfg_q           <= cfg_d;
      end
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   sequence s_mode_reset;
      stack_rst_q && buf_clr_q && rf_rst_q && !rf_tx_en_q;
   endsequence

   sequence s_load_begin;
      !stack_rst_q && nvm_req_q;
   endsequence

   AST_DL_BOOT: assert property (@(posedge clk_sys) disable iff (!por_n)
      (!rst_n && dl_pend_q) |=> download_mode_q && !nvm_req_q)
      else $error("download mode not entered after reset");

   AST_MODE_RESET: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q == RFC_ST_READY && loop_chg) |=> ##1 s_mode_reset ##1 s_load_begin)
      else $error("loop change did not reset and reload");

   AST_NO_TX_LOADING: assert property (@(posedge clk_sys) disable iff (!rst_n)
      nvm_req_q |-> !rf_tx_en_q && !poll_ready_q)
      else $error("transmit enabled during load");

   AST_TX_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q == RFC_ST_READY && !loop_chg && mod_sel == scheme_q && poll_start)
      |=> rf_tx_en_q)
      else $error("polling not started when ready");

   AST_ADDR_ASC: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q == RFC_ST_WAIT && nvm_valid) |=> nvm_addr_q == 16'($past(nvm_addr_q) + 16'h0001))
      else $error("store not read in ascending order");

   AST_SET_MATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stack_rst_q |-> cfg_set_q == ($past(mode_s2_q) ? RFC_LOOP_PAY : RFC_LOOP_GEN))
      else $error("wrong configuration set selected");

   AST_SCHEME_RELOAD: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q == RFC_ST_READY && !loop_chg && mod_sel != scheme_q)
      |=> !poll_ready_q ##1 nvm_req_q [*2])
      else $error("scheme change did not reload");

   AST_LOAD_START: assert property (@(posedge clk_sys) disable iff (!rst_n)
      s_mode_reset |-> ##[1:2] nvm_req_q)
      else $error("load not started after loop activation");

   AST_WORD_OUT: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_q == RFC_ST_WAIT && nvm_valid && bcnt_q == 2'h3 && ELEM_BYTES == 4)
      |=> cfg_q.wr && cfg_q.data[31:24] == $past(nvm_rdata))
      else $error("last byte not in top lane");
endmodule : rfc_loader

/* File: rfc_nvm_model.sv */
// ------------------------------------------------------------
// Non-volatile store model, one byte per read, adjustable wait
// ------------------------------------------------------------
module rfc_nvm_model (
   // Clock and wait control
   input  wire logic        clk_sys,
   input  wire logic [1:0]  lat,
   // Read port
   input  wire logic        nvm_req_q,
   input  wire logic [15:0] nvm_addr_q,
   output logic [7:0]       nvm_rdata,
   output logic             nvm_valid
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt = 2'h0;
   // Read-only store: programmed rarely, never within a run
   // Released data line toggles so stale bytes never look valid
   always @(posedge clk_sys) begin
      nvm_valid <= 1'b0;
      nvm_rdata <= ~nvm_rdata;
      if (nvm_req_q && !nvm_valid) begin
         if (cnt == lat) begin
            nvm_valid <= 1'b1;
            // Each address holds its own byte, stored low byte first
            nvm_rdata <= nvm_addr_q[7:0] ^ nvm_addr_q[15:8];
            cnt       <= 2'h0;
         end else begin
            cnt <= cnt + 2'h1;
         end
      end
   end
endmodule : rfc_nvm_model

/* File: rfc_loader_tb.sv */
`include "rfc_map.svh"
module rfc_loader_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import rfc_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic        clk_sys = 1'b0;
   logic        rst_n = 1'b0;
   logic        por_n = 1'b0;
   logic        mode_pin = 1'b1;
   logic        dl_cmd = 1'b0;
   logic        poll_start = 1'b0;
   logic [1:0]  mod_sel = 2'h0;
   logic [1:0]  lat = 2'h0;
   logic [7:0]  nvm_rdata;
   logic        nvm_valid, nvm_req_q;
   logic [15:0] nvm_addr_q;
   rfc_cfg_wr_t cfg_q, cfg_q_e1, cfg_q_e2;
   logic [7:0]  calibration_control_cell = 8'h00;
   logic [7:0]  tx_calibrate_store_trigger = 8'h00;
   logic        cal_done = 1'b0;
   rfc_loop_t   cfg_set_q;
   logic        download_mode_q, stack_rst_q, buf_clr_q, rf_rst_q, poll_ready_q, rf_tx_en_q;
   int          n_errors = 0;
   int          n_compared = 0;
   always #50 clk_sys = ~clk_sys;
   rfc_loader i_rfc_loader (.clk_sys(clk_sys), .rst_n(rst_n), .por_n(por_n),
      .mode_pin(mode_pin), .dl_cmd(dl_cmd), .mod_sel(mod_sel), .poll_start(poll_start),
      .nvm_rdata(nvm_rdata), .nvm_valid(nvm_valid), .nvm_req_q(nvm_req_q),
      .nvm_addr_q(nvm_addr_q), .cfg_q(cfg_q), .cfg_set_q(cfg_set_q),
      .download_mode_q(download_mode_q), .stack_rst_q(stack_rst_q), .buf_clr_q(buf_clr_q),
      .rf_rst_q(rf_rst_q), .poll_ready_q(poll_ready_q), .rf_tx_en_q(rf_tx_en_q));
   rfc_nvm_model i_rfc_nvm_model (.clk_sys(clk_sys), .lat(lat), .nvm_req_q(nvm_req_q),
      .nvm_addr_q(nvm_addr_q), .nvm_rdata(nvm_rdata), .nvm_valid(nvm_valid));
   // Same stimulus at the other element sizes; the store answers the main instance
   rfc_loader #(.ELEM_BYTES(2)) i_rfc_loader_e2 (.clk_sys(clk_sys), .rst_n(rst_n),
      .por_n(por_n), .mode_pin(mode_pin), .dl_cmd(dl_cmd), .mod_sel(mod_sel),
      .poll_start(poll_start), .nvm_rdata(nvm_rdata), .nvm_valid(nvm_valid), .nvm_req_q(),
      .nvm_addr_q(), .cfg_q(cfg_q_e2), .cfg_set_q(), .download_mode_q(), .stack_rst_q(),
      .buf_clr_q(), .rf_rst_q(), .poll_ready_q(), .rf_tx_en_q());
   rfc_loader #(.ELEM_BYTES(1)) i_rfc_loader_e1 (.clk_sys(clk_sys), .rst_n(rst_n),
      .por_n(por_n), .mode_pin(mode_pin), .dl_cmd(dl_cmd), .mod_sel(mod_sel),
      .poll_start(poll_start), .nvm_rdata(nvm_rdata), .nvm_valid(nvm_valid), .nvm_req_q(),
      .nvm_addr_q(), .cfg_q(cfg_q_e1), .cfg_set_q(), .download_mode_q(), .stack_rst_q(),
      .buf_clr_q(), .rf_rst_q(), .poll_ready_q(), .rf_tx_en_q());
   // ------------------------------------------------------------
   // Helpers
   // ------------------------------------------------------------
   task summarize;
      $display("errors=%0d compared=%0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : summarize
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_errors++;
         $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk
   task cyc;
      @(posedge clk_sys);
      #10;
   endtask : cyc
   task do_reset(input bit pwr);
      rst_n = 1'b0;
      por_n = ~pwr;
      repeat (16) cyc();
      rst_n = 1'b1;
      por_n = 1'b1;
   endtask : do_reset
   // Host transmitter calibration, before the first field, antenna unloaded
   task host_calibrate;
      calibration_control_cell = 8'h00;
      cyc();
      tx_calibrate_store_trigger = 8'h01;
      cyc();
      calibration_control_cell = 8'h02;
      cyc();
      cal_done = 1'b1;
   endtask : host_calibrate
   // Follows one whole set load, then starts transmission
   task check_load(input logic loop, input logic [1:0] ms);
      logic [15:0] a;
      logic [31:0] w, w1, w2;
      int          t;
      for (int i = 0; i < `RFC_SET_WORDS; i++) begin
         t = 0;
         do begin
            cyc();
            t++;
         end while (cfg_q.wr !== 1'b1 && t < 200);
         chk(32'(cfg_q.wr), 32'h1);
         for (int k = 0; k < 4; k++) begin
            a = (loop ? `RFC_PAY_BASE : `RFC_GEN_BASE) + 16'(ms) * `RFC_SCHEME_BYTES;
            a = a + 16'(i * 4 + k);
            w[k*8 +: 8] = a[7:0] ^ a[15:8];
            w1[(3 - k)*8 +: 8] = a[7:0] ^ a[15:8];
            w2[((k + 2) % 4)*8 +: 8] = a[7:0] ^ a[15:8];
         end
         chk(cfg_q.data, w);
         chk(cfg_q_e2.data, w2);
         chk(cfg_q_e1.data, w1);
         chk(32'(cfg_q.idx), 32'(i));
      end
      cyc();
      chk(32'(poll_ready_q), 32'h1);
      chk(32'(cfg_set_q), 32'(loop));
      chk(32'(rf_tx_en_q), 32'h0);
      poll_start = cal_done;
      cyc();
      cyc();
      chk(32'(rf_tx_en_q), 32'h1);
      poll_start = 1'b0;
   endtask : check_load
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task t_boot;
      host_calibrate();
      do_reset(1'b1);
      check_load(1'b1, 2'h0);
   endtask : t_boot
   task t_loop_change;
      int t;
      lat = 2'h2;
      mode_pin = 1'b0;
      t = 0;
      do begin
         cyc();
         t++;
      end while (stack_rst_q !== 1'b1 && t < 20);
      chk(32'(stack_rst_q), 32'h1);
      chk(32'(buf_clr_q), 32'h1);
      chk(32'(rf_rst_q), 32'h1);
      chk(32'(rf_tx_en_q), 32'h0);
      check_load(1'b0, 2'h0);
   endtask : t_loop_change
   task t_scheme;
      lat = 2'h1;
      for (int ms = 1; ms < 4; ms++) begin
         mod_sel = 2'(ms);
         check_load(1'b0, 2'(ms));
      end
   endtask : t_scheme
   task t_download;
      dl_cmd = 1'b1;
      cyc();
      dl_cmd = 1'b0;
      do_reset(1'b0);
      repeat (20) begin
         cyc();
         chk(32'(nvm_req_q), 32'h0);
      end
      chk(32'(download_mode_q), 32'h1);
      do_reset(1'b1);
      cyc();
      chk(32'(download_mode_q), 32'h0);
      check_load(1'b0, 2'h3);
   endtask : t_download
   initial begin
      t_boot();
      t_loop_change();
      t_scheme();
      t_download();
      summarize();
   end
   initial begin
      #(100 * 30000);
      n_errors++;
      summarize();
   end
endmodule : rfc_loader_tb
